// [pkg/adcsp_pkg.sv]
package adcsp_pkg;

    // Clock of the block and the fastest serial clock the host may use.
    localparam int         CLK_MHZ          = 125;
    localparam int         SCK_MAX_MHZ      = 20;
    // System cycles in one serial clock period at the fastest rate.
    localparam int         SCK_MIN_CYCLES   = CLK_MHZ / SCK_MAX_MHZ;

    // Widths of the divider chain.
    localparam int         PRE_W            = 3;
    localparam int         SMP_W            = 2;
    localparam int         OVS_W            = 12;

    // Prescale ratio for code zero (divide by one) and one step.
    localparam logic [PRE_W-1:0] PRE_ONE    = 3'h1;
    // Modulator ticks per sample tick, minus one (divide by four).
    localparam logic [SMP_W-1:0] SMP_LIMIT  = 2'h3;
    // Smallest oversampling ratio; each code step doubles it.
    localparam logic [OVS_W:0]   OVS_MIN    = 13'h0020;
    localparam logic [OVS_W:0]   OVS_ONE    = 13'h0001;
    // Last ready pulse count in modulator ticks; two ticks are half of a sample period.
    localparam logic [SMP_W-1:0] HALF_LAST  = 2'h1;

    // Reset defaults of the configuration bits.
    localparam logic       DRIVE_DEFAULT    = 1'b0;
    localparam logic       EXTCLK_DEFAULT   = 1'b0;
    localparam logic [1:0] PRE_DEFAULT      = 2'h0;
    localparam logic [2:0] OVS_DEFAULT      = 3'h0;

    // Command byte layout: bit zero set means read.
    localparam int         CMD_READ_BIT     = 0;
    localparam logic [2:0] BIT_LAST         = 3'h7;
    localparam logic [2:0] BIT_FIRST        = 3'h0;
    localparam logic [7:0] BYTE_ZERO        = 8'h00;

    // Serial port states, Gray coded in the order idle, command, write, read.
    typedef enum logic [1:0]
    {
        SP_IDLE  = 2'b00,
        SP_CMD   = 2'b01,
        SP_WRITE = 2'b11,
        SP_READ  = 2'b10
    } adcsp_state_e;

endpackage : adcsp_pkg

// [verilog/adcsp_div.sv]
`timescale 1ns/100ps

// Counts input ticks and emits one registered tick every limit+1 of them.
module adcsp_div
    import adcsp_pkg::*;
#(
    parameter int W = 4
)
(
    input  wire logic         clk,
    input  wire logic         ce,
    input  wire logic         clr,
    input  wire logic         tick_in,
    input  wire logic [W-1:0] limit,
    output logic              tick_out
);

    logic [W-1:0] cnt;    // Ticks seen since the last output tick.

    // A limit change takes effect cleanly because the count also wraps to zero at
    // any value above the new limit instead of running round the full width.
    always_ff @(posedge clk)
    begin
        if (clr)
        begin
            cnt      <= '0;
            tick_out <= 1'b0;
        end
        else if (ce)
        begin
            tick_out <= 1'b0;
            if (tick_in)
            begin
                if (cnt >= limit)
                begin
                    cnt      <= '0;
                    tick_out <= 1'b1;
                end
                else
                begin
                    cnt <= cnt + 1'b1;
                end
            end
        end
    end

endmodule : adcsp_div

// [verilog/adcsp_top.sv]
`timescale 1ns/100ps

// Contract
// RULE_01: Drive select high idles ready high, else floats.
// RULE_02: Each conversion end gives one low ready pulse.
// RULE_03: Pulse lasts half sample period, repeats per rate; code ends it two cycles early when a modulator period exceeds two cycles.
// RULE_04: Ready unlatched, independent of serial port.
// RULE_05: External select picks pin clock, disables oscillator.
// RULE_06: Select falling starts, rising ends; high ignores all.
// RULE_07: Master reset low refuses all serial traffic.
// RULE_08: Input data sampled on rising serial clock.
// RULE_09: Output data shifted on falling serial clock.
// RULE_10: Serial modes 0,0 and 1,1 both work.
// RULE_11: Serial clock asynchronous, at most 20 MHz.
// RULE_12: Output floats except while serving a read.
// RULE_13: Half duplex: never input and output together.
// RULE_14: First byte is command, decoded read or write.
// RULE_15: Input ignored after read command or select high.
// RULE_16: Master reset returns all state to defaults.
// RULE_17: Operational immediately after master reset release.
// RULE_18: Prescale divides master clock by 1, 2, 4, 8.
// RULE_19: Sample clock is modulator clock divided by four.
// RULE_20: Output rate is sample clock over ratio 32..4096.
module adcsp_top
    import adcsp_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic       CE,
    input  wire logic       SRST,
    input  wire logic       MASTER_RESET_N,
    input  wire logic       EXTERNAL_CLOCK_SELECT,
    input  wire logic       READY_PIN_DRIVE_SELECT,
    input  wire logic [1:0] PRESCALE_SELECT,
    input  wire logic [2:0] OVERSAMPLE_RATIO,
    input  wire logic       CRYSTAL_IN_CLOCK_PIN,
    output logic            CRYSTAL_OUT_PIN,
    output logic            DATA_READY_N_O,
    output logic            DATA_READY_N_OE,
    input  wire logic       CHIP_SELECT_N,
    input  wire logic       SCK,
    input  wire logic       SDI,
    output logic            SDO_O,
    output logic            SDO_OE,
    output logic [7:0]      CMD_BYTE,
    output logic            CMD_VALID,
    output logic [7:0]      WR_DATA,
    output logic            WR_VALID,
    input  wire logic [7:0] RD_DATA,
    output logic            RD_REQ
);

    // Synchroniser stages for the reset, clock and serial pins; stage one feeds stage two only.
    logic       mrst_s1;      // Master reset pin, first stage.
    logic       mrst_s2;      // Master reset pin, second stage.
    logic       ci_s1;        // Clock input pin, first stage.
    logic       ci_s2;        // Clock input pin, second stage.
    logic       ci_s3;        // Clock input pin, delayed for edge finding.
    logic       cs_s1;        // Chip select, first stage.
    logic       cs_s2;        // Chip select, second stage.
    logic       cs_s3;        // Chip select, delayed for edge finding.
    logic       sck_s1;       // Serial clock, first stage.
    logic       sck_s2;       // Serial clock, second stage.
    logic       sck_s3;       // Serial clock, delayed for edge finding.
    logic       sdi_s1;       // Serial input, first stage.
    logic       sdi_s2;       // Serial input, second stage.

    // Configuration as held by the device, forced to defaults in reset.
    logic       cfg_drive;    // Ready pin drives high while idle.
    logic       cfg_extclk;   // Master clock taken from the pin.
    logic [1:0] cfg_pre;      // Prescale code.
    logic [2:0] cfg_ovs;      // Oversampling code.

    // Divider chain ticks.
    logic       mclk_tick;    // One master clock period has passed.
    logic       modck_tick;   // One modulator clock period has passed.
    logic       smpck_tick;   // One sample clock period has passed.
    logic       rate_tick;    // One output rate period has passed.
    logic [PRE_W-1:0] pre_limit; // Prescale count limit.
    logic [OVS_W:0]   ovs_full;  // Oversampling ratio in full.
    logic [OVS_W-1:0] ovs_limit; // Oversampling count limit.

    // Ready pulse state.
    logic       pulse;        // Ready pulse is low on the pin.
    logic [SMP_W-1:0] half_cnt; // Modulator ticks into the pulse.

    // Serial port state.
    adcsp_state_e state;      // Transaction phase.
    logic [2:0] bit_cnt;      // Bit position within the byte.
    logic [7:0] in_sh;        // Incoming byte assembly.
    logic [7:0] out_sh;       // Outgoing byte shifter.

    // Edge and reset terms.
    logic       hard_rst;     // Either reset holds the device.
    logic       sck_rise;     // Serial clock rose.
    logic       sck_fall;     // Serial clock fell.
    logic       cs_fall;      // Chip select fell.
    logic       cs_rise;      // Chip select rose.
    logic       cs_low;       // Chip select held low.
    logic [7:0] next_in;      // Byte with the sampled bit shifted in.

    // Every reset, clock and serial pin crosses two flip-flops; the third stage exists only
    // for edge detection and reads the second stage, never the first.
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            mrst_s1 <= 1'b0;
            mrst_s2 <= 1'b0;
            ci_s1   <= 1'b0;
            ci_s2   <= 1'b0;
            ci_s3   <= 1'b0;
            cs_s1   <= 1'b1;
            cs_s2   <= 1'b1;
            cs_s3   <= 1'b1;
            sck_s1  <= 1'b0;
            sck_s2  <= 1'b0;
            sck_s3  <= 1'b0;
            sdi_s1  <= 1'b0;
            sdi_s2  <= 1'b0;
        end
        else if (CE)
        begin
            mrst_s1 <= MASTER_RESET_N;
            mrst_s2 <= mrst_s1;
            ci_s1   <= CRYSTAL_IN_CLOCK_PIN;
            ci_s2   <= ci_s1;
            ci_s3   <= ci_s2;
            cs_s1   <= CHIP_SELECT_N;
            cs_s2   <= cs_s1;
            cs_s3   <= cs_s2;
            sck_s1  <= SCK;  // see RULE_11
            sck_s2  <= sck_s1;
            sck_s3  <= sck_s2;
            sdi_s1  <= SDI;
            sdi_s2  <= sdi_s1;
        end
    end

    // Oversampling the serial pins at CLK_MHZ leaves about SCK_MIN_CYCLES
    // samples per serial period at top rate, so both edges are always seen.
    assign hard_rst = SRST | ~mrst_s2;
    assign sck_rise = sck_s2 & ~sck_s3;
    assign sck_fall = ~sck_s2 & sck_s3;
    assign cs_fall  = ~cs_s2 & cs_s3;
    assign cs_rise  = cs_s2 & ~cs_s3;
    assign cs_low   = ~cs_s2;
    assign next_in  = {in_sh[6:0], sdi_s2};

    // Configuration bits follow their ports but fall back to defaults for as
    // long as the master reset is held.
    always_ff @(posedge CLK)
    begin
        if (hard_rst)
        begin
            cfg_drive  <= DRIVE_DEFAULT;   // see RULE_16
            cfg_extclk <= EXTCLK_DEFAULT;
            cfg_pre    <= PRE_DEFAULT;
            cfg_ovs    <= OVS_DEFAULT;
        end
        else if (CE)
        begin
            cfg_drive  <= READY_PIN_DRIVE_SELECT;
            cfg_extclk <= EXTERNAL_CLOCK_SELECT;
            cfg_pre    <= PRESCALE_SELECT;
            cfg_ovs    <= OVERSAMPLE_RATIO;
        end
    end

    // The oscillator stands in as one master tick per system cycle; with the
    // pin selected each rising edge of the pin is one tick instead.
    assign mclk_tick = cfg_extclk ? (ci_s2 & ~ci_s3) : 1'b1;  // see RULE_05

    // The oscillator output drives the crystal in antiphase while enabled and
    // is held low when the external clock path is chosen.
    always_ff @(posedge CLK)
    begin
        if (hard_rst)
        begin
            CRYSTAL_OUT_PIN <= 1'b0;
        end
        else if (CE)
        begin
            CRYSTAL_OUT_PIN <= cfg_extclk ? 1'b0 : ~ci_s2;  // see RULE_05
        end
    end

    // Divider limits; the ratio is a power of two so a shift suffices.
    assign pre_limit = PRE_W'((PRE_ONE << cfg_pre) - PRE_ONE);  // see RULE_18
    assign ovs_full  = OVS_MIN << cfg_ovs;                      // see RULE_20
    assign ovs_limit = OVS_W'(ovs_full - OVS_ONE);

    // The chain is cleared only by reset, never by serial activity, so the
    // ready timing rests on clock and settings alone.
    adcsp_div #(.W(PRE_W)) u_pre
    (
        .clk      (CLK),
        .ce       (CE),
        .clr      (hard_rst),
        .tick_in  (mclk_tick),
        .limit    (pre_limit),
        .tick_out (modck_tick)
    );  // see RULE_18

    adcsp_div #(.W(SMP_W)) u_smp
    (
        .clk      (CLK),
        .ce       (CE),
        .clr      (hard_rst),
        .tick_in  (modck_tick),
        .limit    (SMP_LIMIT),
        .tick_out (smpck_tick)
    );  // see RULE_19

    adcsp_div #(.W(OVS_W)) u_ovs
    (
        .clk      (CLK),
        .ce       (CE),
        .clr      (hard_rst),
        .tick_in  (smpck_tick),
        .limit    (ovs_limit),
        .tick_out (rate_tick)
    );  // see RULE_20

    // A ready pulse opens on each output rate tick and closes after two
    // modulator ticks, half of one sample period while a modulator tick spans at most two cycles, two cycles less otherwise; it is never latched.
    always_ff @(posedge CLK)
    begin
        if (hard_rst)
        begin
            pulse    <= 1'b0;
            half_cnt <= '0;
        end
        else if (CE)
        begin
            if (rate_tick)
            begin
                pulse    <= 1'b1;  // see RULE_02
                half_cnt <= '0;
            end
            else if (pulse && modck_tick)
            begin
                // Closing by count rather than by host action.
                if (half_cnt == HALF_LAST)
                begin
                    pulse <= 1'b0;  // see RULE_03
                end
                half_cnt <= half_cnt + 1'b1;  // see RULE_04
            end
        end
    end

    // Ready pin: low while pulsing, otherwise high or floating per setting.
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            DATA_READY_N_O  <= 1'b1;
            DATA_READY_N_OE <= 1'b0;
        end
        else if (CE)
        begin
            DATA_READY_N_O  <= ~pulse;
            DATA_READY_N_OE <= pulse | cfg_drive;  // see RULE_01
        end
    end

    // Transaction phase. Reset and a high select both hold the port idle;
    // a select rise ends any phase at once.
    always_ff @(posedge CLK)
    begin
        if (hard_rst)
        begin
            state <= SP_IDLE;  // see RULE_07
        end
        else if (CE)
        begin
            unique case (state)
                SP_IDLE:
                begin
                    // Mode is whatever SCK idles at; nothing depends on it.
                    if (cs_fall)
                    begin
                        state <= SP_CMD;  // see RULE_06
                    end
                end
                SP_CMD:
                begin
                    if (cs_rise || !cs_low)
                    begin
                        state <= SP_IDLE;
                    end
                    else if (sck_rise && bit_cnt == BIT_LAST)
                    begin
                        // see RULE_14
                        state <= next_in[CMD_READ_BIT] ? SP_READ : SP_WRITE;
                    end
                end
                SP_WRITE, SP_READ:
                begin
                    if (cs_rise || !cs_low)
                    begin
                        state <= SP_IDLE;  // see RULE_06
                    end
                end
            endcase
        end
    end

    // Input side: bits are taken on rising edges during command and write
    // phases only, so a read phase or a high select leaves SDI unheard.
    always_ff @(posedge CLK)
    begin
        if (hard_rst)
        begin
            bit_cnt   <= BIT_FIRST;
            in_sh     <= BYTE_ZERO;
            CMD_BYTE  <= BYTE_ZERO;
            CMD_VALID <= 1'b0;
            WR_DATA   <= BYTE_ZERO;
            WR_VALID  <= 1'b0;
        end
        else if (CE)
        begin
            CMD_VALID <= 1'b0;
            WR_VALID  <= 1'b0;
            if (state == SP_IDLE || !cs_low)
            begin
                bit_cnt <= BIT_FIRST;  // see RULE_15
            end
            else if (state == SP_READ)
            begin
                // Count falling edges here, the output byte boundary.
                if (sck_fall)
                begin
                    bit_cnt <= bit_cnt + 1'b1;
                end
            end
            else if (sck_rise)
            begin
                in_sh   <= next_in;  // see RULE_08
                bit_cnt <= bit_cnt + 1'b1;
                if (bit_cnt == BIT_LAST)
                begin
                    if (state == SP_CMD)
                    begin
                        CMD_BYTE  <= next_in;  // see RULE_14
                        CMD_VALID <= 1'b1;
                    end
                    else
                    begin
                        WR_DATA  <= next_in;
                        WR_VALID <= 1'b1;
                    end
                end
            end
        end
    end

    // Output side: the first byte is fetched with the command's last bit,
    // each later byte with the last falling edge of the byte before it.
    always_ff @(posedge CLK)
    begin
        if (hard_rst)
        begin
            out_sh <= BYTE_ZERO;
            SDO_O  <= 1'b0;
            RD_REQ <= 1'b0;
        end
        else if (CE)
        begin
            RD_REQ <= 1'b0;
            if (state == SP_CMD && cs_low && sck_rise &&
                bit_cnt == BIT_LAST && next_in[CMD_READ_BIT])
            begin
                out_sh <= RD_DATA;
                RD_REQ <= 1'b1;
            end
            else if (state == SP_READ && cs_low && sck_fall)
            begin
                SDO_O <= out_sh[7];  // see RULE_09
                if (bit_cnt == BIT_LAST)
                begin
                    // Fetch overlaps the last bit; RD_DATA must be ready.
                    out_sh <= RD_DATA;
                    RD_REQ <= 1'b1;
                end
                else
                begin
                    out_sh <= {out_sh[6:0], 1'b0};
                end
            end
        end
    end

    // The output drives only in the read phase with select low, which keeps
    // input and output apart in time for the whole transaction.
    always_ff @(posedge CLK)
    begin
        if (hard_rst)
        begin
            SDO_OE <= 1'b0;  // see RULE_12
        end
        else if (CE)
        begin
            // see RULE_13
            SDO_OE <= (state == SP_READ) && cs_low && !cs_rise;
        end
    end

    // Release of the master reset needs no warm-up: dividers start from zero
    // and the serial port is idle on the very next cycle.
    // see RULE_17
    // see RULE_10

endmodule : adcsp_top

// [sim/adcsp_asserts.sv]
`timescale 1ns/100ps
// Pin-level checks on the serial port and the ready line.
module adcsp_asserts
(
    input wire logic       CLK,
    input wire logic       SRST,
    input wire logic       MASTER_RESET_N,
    input wire logic       EXTERNAL_CLOCK_SELECT,
    input wire logic       READY_PIN_DRIVE_SELECT,
    input wire logic [1:0] PRESCALE_SELECT,
    input wire logic [2:0] OVERSAMPLE_RATIO,
    input wire logic       DATA_READY_N_O,
    input wire logic       DATA_READY_N_OE,
    input wire logic       CHIP_SELECT_N,
    input wire logic       SCK,
    input wire logic       SDO_O,
    input wire logic       SDO_OE,
    input wire logic       CMD_VALID,
    input wire logic       WR_VALID
);
    logic       rdy_q; // Ready level one cycle ago.
    logic [4:0] cfg_q; // Divider settings one cycle ago.
    logic       armed; // A fall was seen under the present settings.
    int         gap;   // Cycles since the last ready fall.
    int         per;   // Expected cycles between falls.

    assign per = 128 << (int'(PRESCALE_SELECT) + int'(OVERSAMPLE_RATIO));

    // Time the ready falls. Any reset or change of settings spoils the
    // next interval, so timing restarts from the following fall.
    always_ff @(posedge CLK)
    begin
        rdy_q <= DATA_READY_N_O;
        cfg_q <= {PRESCALE_SELECT, OVERSAMPLE_RATIO};
        if (SRST || !MASTER_RESET_N || EXTERNAL_CLOCK_SELECT ||
            cfg_q != {PRESCALE_SELECT, OVERSAMPLE_RATIO})
        begin
            armed <= 1'b0;
            gap   <= 0;
        end
        else if (rdy_q && !DATA_READY_N_O)
        begin
            armed <= 1'b1;
            gap   <= 1;
        end
        else
            gap <= gap + 1;
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    sdo_idle_cs_a: assert property
        (CHIP_SELECT_N [*6] |-> !SDO_OE) else $error("sdo driven idle");
    sdo_rst_a: assert property
        (!MASTER_RESET_N [*5] |-> !SDO_OE && !CMD_VALID && !WR_VALID)
        else $error("serial active in reset");
    half_duplex_a: assert property
        (CMD_VALID || WR_VALID |-> !SDO_OE) else $error("sdo during input");
    sdo_fall_a: assert property
        ($changed(SDO_O) && SDO_OE |-> !$past(SCK, 3))
        else $error("sdo moved off falling edge");
    rdy_low_oe_a: assert property
        (!DATA_READY_N_O |-> DATA_READY_N_OE) else $error("ready low floats");
    rdy_float_a: assert property
        (!READY_PIN_DRIVE_SELECT [*3] ##0 DATA_READY_N_O |-> !DATA_READY_N_OE)
        else $error("ready idle driven");
    rdy_period_a: assert property
        ($fell(DATA_READY_N_O) && armed |-> gap == per)
        else $error("ready period wrong");
    rdy_width_a: assert property
        (disable iff (SRST || !MASTER_RESET_N)
         $fell(DATA_READY_N_O) && PRESCALE_SELECT == 2'h0 &&
         !EXTERNAL_CLOCK_SELECT |-> !DATA_READY_N_O [*2] ##1 DATA_READY_N_O)
        else $error("ready width wrong");

    cover property (SDO_OE && $fell(SCK));
    cover property (WR_VALID);
    cover property ($fell(DATA_READY_N_O) && armed);
endmodule : adcsp_asserts

bind adcsp_top adcsp_asserts chk_u
(
    .CLK(CLK), .SRST(SRST), .MASTER_RESET_N(MASTER_RESET_N),
    .EXTERNAL_CLOCK_SELECT(EXTERNAL_CLOCK_SELECT),
    .READY_PIN_DRIVE_SELECT(READY_PIN_DRIVE_SELECT),
    .PRESCALE_SELECT(PRESCALE_SELECT), .OVERSAMPLE_RATIO(OVERSAMPLE_RATIO),
    .DATA_READY_N_O(DATA_READY_N_O), .DATA_READY_N_OE(DATA_READY_N_OE),
    .CHIP_SELECT_N(CHIP_SELECT_N), .SCK(SCK), .SDO_O(SDO_O),
    .SDO_OE(SDO_OE), .CMD_VALID(CMD_VALID), .WR_VALID(WR_VALID)
);

// [sim/adcsp_host.sv]
`timescale 1ns/100ps
// Behavioural serial host on the far side of the port.
module adcsp_host
(
    input  wire logic  clk,
    input  wire logic  sdo_o,
    input  wire logic  sdo_oe,
    output logic       cs_n,
    output logic       sck,
    output logic       sdi,
    output logic [7:0] rx_b,
    output logic       rx_v
);
    logic mode;  // Clock idle level: 0 for mode 0,0, 1 for 1,1.
    logic last;  // Last bit the device drove.
    logic sdo_w; // Level seen on the output wire.

    // A released wire shows the inverse of its last bit, so a float
    // never reads back as good data.
    assign sdo_w = sdo_oe ? sdo_o : ~last;

    initial
    begin
        {cs_n, sck, sdi, rx_v, mode, last} = 6'h20;
        rx_b = 8'h00;
    end

    // Keep the input line busy between frames; it must be ignored.
    always @(posedge clk)
    begin
        if (cs_n)
            sdi <= #1 ~sdi;
        if (sdo_oe)
            last <= sdo_o;
    end

    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // The mode only changes while chip select is high.
    task open(input logic m);
        mode = m;
        sck = m;
        tick(2);
        cs_n = 1'b0;
        tick(5);
    endtask : open

    task close;
        sck = mode;
        tick(5);
        cs_n = 1'b1;
        tick(8);
    endtask : close

    // Bits go MSB first, set up before each rise; the wire is read at
    // that rise. Each level lasts 5 cycles, well under the top rate.
    task xfer(input logic [7:0] tx, input int nb, input logic rd);
        logic [7:0] rx;
        rx = 8'h00;
        for (int i = 7; i > 7 - nb; i--)
        begin
            sck = 1'b0;
            sdi = tx[i];
            tick(5);
            sck = 1'b1;
            rx = {rx[6:0], sdo_w};
            tick(5);
        end
        rx_b = rx;
        rx_v = rd;
        tick(1);
        rx_v = 1'b0;
    endtask : xfer
endmodule : adcsp_host

// [sim/adcsp_top_tb.sv]
`timescale 1ns/100ps
// Bench: the host model works the serial port while the ready line is
// timed against the divider settings.
module adcsp_top_tb;
    logic       clk = 1'b0, srst = 1'b1, mrst_n = 1'b1; // Clock, resets.
    logic       ext = 1'b0, drv = 1'b0;  // Clock and drive selects.
    logic       pin = 1'b0, tog = 1'b0;  // Clock pin and its enable.
    logic [1:0] pre = 2'h0;              // Prescale code.
    logic [2:0] ovs = 3'h0;              // Oversampling code.
    logic [7:0] rd_data = 8'h00;         // Byte offered for reads.
    logic       rdy_o, rdy_oe, xout, sdo_o, sdo_oe, cmd_v, wr_v, rd_req;
    logic       cs_n, sck, sdi, rx_v;
    logic [7:0] cmd_b, wr_d, rx_b;
    logic [7:0] exp_q[$];                // Command and write bytes.
    logic [7:0] rd_q[$];                 // Bytes loaded for output.
    int         bad_count = 0, tests_run = 0, seed = 75, cnt, per;

    adcsp_top dut_u
    (
        .CLK(clk), .CE(1'b1), .SRST(srst), .MASTER_RESET_N(mrst_n),
        .EXTERNAL_CLOCK_SELECT(ext), .READY_PIN_DRIVE_SELECT(drv),
        .PRESCALE_SELECT(pre), .OVERSAMPLE_RATIO(ovs),
        .CRYSTAL_IN_CLOCK_PIN(pin), .CRYSTAL_OUT_PIN(xout),
        .DATA_READY_N_O(rdy_o), .DATA_READY_N_OE(rdy_oe),
        .CHIP_SELECT_N(cs_n), .SCK(sck), .SDI(sdi), .SDO_O(sdo_o),
        .SDO_OE(sdo_oe), .CMD_BYTE(cmd_b), .CMD_VALID(cmd_v),
        .WR_DATA(wr_d), .WR_VALID(wr_v), .RD_DATA(rd_data), .RD_REQ(rd_req)
    );

    adcsp_host host_u
    (
        .clk(clk), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .cs_n(cs_n),
        .sck(sck), .sdi(sdi), .rx_b(rx_b), .rx_v(rx_v)
    );

    always #4 clk = ~clk;

    // Clock pin runs at half the system rate when enabled.
    always @(posedge clk)
        if (tog)
            pin <= #1 ~pin;

    task chk(input string nm, input logic [31:0] seen,
             input logic [31:0] want);
        tests_run++;
        if (seen !== want)
        begin
            bad_count++;
            $display("[ERR] %s expected %0h seen %0h", nm, want, seen);
        end
    endtask : chk

    task results;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results

    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // Counts cycles to the next ready fall, giving up at lim.
    task wait_fall(input int lim, output int c);
        logic p;
        p = rdy_o;
        c = 0;
        while (c < lim && !(p === 1'b1 && rdy_o === 1'b0))
        begin
            p = rdy_o;
            tick(1);
            c++;
        end
    endtask : wait_fall

    // One frame: command, n bytes, the last one nb bits long. Only
    // whole bytes taken while live are noted as expected.
    task frame(input logic m, rd, input int n, nb, input logic live);
        logic [7:0] b;
        rd_q.delete();
        host_u.open(m);
        for (int k = 0; k <= n; k++)
        begin
            b = 8'($random(seed));
            if (k == 0)
                b[0] = rd;
            if (live && (k == 0 || (!rd && (k < n || nb == 8))))
                exp_q.push_back(b);
            host_u.xfer(b, (k == n && k > 0) ? nb : 8, rd && k > 0);
        end
        host_u.close();
    endtask : frame

    // Results are matched to the oldest note as they appear.
    always @(posedge clk)
    begin
        if (cmd_v === 1'b1)
            chk("cmd", cmd_b,
                exp_q.size() ? exp_q.pop_front() : 'x);
        if (wr_v === 1'b1)
            chk("wr", wr_d,
                exp_q.size() ? exp_q.pop_front() : 'x);
        if (rx_v === 1'b1)
            chk("rd", rx_b,
                rd_q.size() ? rd_q.pop_front() : 'x);
        if (rd_req === 1'b1)
        begin
            rd_q.push_back(rd_data);
            rd_data <= #1 8'($random(seed));
        end
    end

    initial
    begin
        tick(2);
        srst = 1'b0;
        tick(4);
        for (int k = 0; k < 4; k++)
            frame(k[0], k[1], 2, 8, 1'b1);
        frame(1'b0, 1'b0, 2, 4, 1'b1);
        mrst_n = 1'b0;
        drv = 1'b1;
        frame(1'b0, 1'b0, 1, 8, 1'b0);
        chk("oe_rst", rdy_oe, 1'b0);
        for (int i = 0; i < 11; i++)
        begin
            pre = (i < 8) ? 2'h0 : 2'(i - 7);
            ovs = (i < 8) ? 3'(i) : 3'h0;
            drv = 1'($random(seed));
            per = 128 << (i < 8 ? i : i - 7);
            mrst_n = 1'b0;
            tick(6);
            mrst_n = 1'b1;
            wait_fall(per + 20, cnt);
            chk("first", cnt < per + 20, 1'b1);
            wait_fall(per + 20, cnt);
            chk("period", cnt, per);
            tick(per / 2);
            chk("idle", {rdy_o, rdy_oe}, {1'b1, drv});
        end
        {pre, ovs, ext, mrst_n} = 7'h02;
        tick(6);
        mrst_n = 1'b1;
        wait_fall(300, cnt);
        chk("no_fall", cnt, 300);
        chk("osc_out", xout, 1'b0);
        tog = 1'b1;
        wait_fall(600, cnt);
        wait_fall(600, cnt);
        chk("pin_period", cnt, 256);
        chk("left", exp_q.size(), 0);
        results();
    end

    initial
    begin
        repeat (98000) @(posedge clk);
        bad_count++;
        results();
    end
endmodule : adcsp_top_tb
